/* File: hdl/jmg_top.sv */
// Mode decode, ILAS octet generator, APB registers and output FIFO
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/100ps
`include "jmg_defines.svh"

// ---------------------------------------------------------------
// Output FIFO
// ---------------------------------------------------------------
module jmg_fifo #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   wire [AW:0] depth_c = (AW+1)'(DEPTH);
   assign in_ready = (cnt_q != depth_c);
   assign out_valid = (cnt_q != '0);
   assign out_data = mem_q[rd_q];
   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : jmg_fifo

// ---------------------------------------------------------------
// Top
// ---------------------------------------------------------------
module jmg_top #(
   parameter int FIFO_DEPTH = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // ILAS octet stream: link, lane, octet
   output logic cfg_valid,
   input wire logic cfg_ready,
   output logic cfg_link,
   output logic [2:0] cfg_lane,
   output logic [7:0] cfg_octet,
   // Serializer and lane control
   output logic link_rst,
   output logic ser_pd,
   output logic clk_gate_en,
   output logic interleave,
   output logic [4:0] pll_mult_x4,
   output logic pll_bypass,
   output logic [7:0] lane_en_a,
   output logic [7:0] lane_en_b
);
   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic en_q;
   logic scr_q;
   logic [4:0] mode_q;
   logic [4:0] fpm_q;
   logic [7:0] did_q;
   logic [31:0] prdata_q;
   logic [3:0] oct_q;
   logic [2:0] lane_q;
   logic link_q;
   jmg_pkg::jmg_state_e st_q;
   jmg_pkg::jmg_state_e st_d;
   // ------------------------------------------------------------
   // Mode decode
   // ------------------------------------------------------------
   wire m_s4 = (mode_q == `JMG_MODE_S4);
   wire m_s8 = (mode_q == `JMG_MODE_S8);
   wire m_d4 = (mode_q == `JMG_MODE_D4);
   wire m_d8 = (mode_q == `JMG_MODE_D8);
   wire m_s16 = (mode_q == `JMG_MODE_S16);
   wire m_d16 = (mode_q == `JMG_MODE_D16);
   wire mode_ok = m_s4 | m_s8 | m_d4 | m_d8 | m_s16 | m_d16;
   wire des = m_s4 | m_s8 | m_s16;
   wire [4:0] l_m1 = (m_s4 | m_d4) ? 5'h01 :
                     (m_s8 | m_d8) ? 5'h03 : 5'h07;
   // One converter per link, so samples per frame equal lanes
   wire [4:0] s_m1 = l_m1;
   wire [4:0] rx4 = (m_s4 | m_d4) ? `JMG_RX4_L2 :
                    (m_s8 | m_d8) ? `JMG_RX4_L4 :
                    `JMG_RX4_L8;
   wire [7:0] lane_mask = 8'(({1'b0, l_m1} + 6'h01) == 6'h08 ?
                          8'hff : (8'h01 << (l_m1 + 5'h01)) - 8'h01);
   assign interleave = des;
   assign pll_mult_x4 = rx4;
   assign pll_bypass = (rx4 == `JMG_PLL_BYPASS_RX4);
   assign lane_en_a = en_q ? lane_mask : 8'h00;
   assign lane_en_b = en_q ? lane_mask : 8'h00;
   assign link_rst = !en_q;
   assign ser_pd = !en_q;
   assign clk_gate_en = en_q;
   // ------------------------------------------------------------
   // APB decode
   // ------------------------------------------------------------
   wire setup = psel && !penable;
   wire acc = psel && penable;
   wire a_ctrl = (paddr == `JMG_ADDR_CTRL);
   wire a_mode = (paddr == `JMG_ADDR_MODE);
   wire a_fpm = (paddr == `JMG_ADDR_FPM);
   wire a_did = (paddr == `JMG_ADDR_DID);
   wire a_stat = (paddr == `JMG_ADDR_STAT);
   wire a_hit = a_ctrl | a_mode | a_fpm | a_did | a_stat;
   wire [4:0] wmode = pwdata[4:0];
   wire [4:0] wfpm = pwdata[4:0];
   wire wmode_ok = (wmode == `JMG_MODE_S4) | (wmode == `JMG_MODE_S8) |
                   (wmode == `JMG_MODE_D4) | (wmode == `JMG_MODE_D8) |
                   (wmode == `JMG_MODE_S16) | (wmode == `JMG_MODE_D16);
   wire wfpm_ok = (wfpm >= `JMG_FPM_MIN) && wfpm[0];
   // Link parameters except scrambling may only change while the link is disabled
   wire lock_err = en_q && (a_mode | a_fpm | a_did);
   wire wr_err = !a_hit || lock_err || (a_stat) ||
                 (a_mode && !wmode_ok) || (a_fpm && !wfpm_ok);
   wire err = pwrite ? wr_err : !a_hit;
   wire wr_ok = acc && pwrite && !wr_err;
   wire gen_busy = (st_q != jmg_pkg::JMG_DONE) && en_q;
   wire [31:0] rd_mux =
      a_ctrl ? {30'h0, scr_q, en_q} :
      a_mode ? {27'h0, mode_q} :
      a_fpm ? {27'h0, fpm_q} :
      a_did ? {24'h0, did_q} :
      a_stat ? {12'h0, lane_mask, 3'h0, pll_bypass, rx4,
                des, gen_busy, mode_ok} : 32'h0;
   assign pready = 1'b1;
   assign pslverr = acc && err;
   assign prdata = prdata_q;
   always_ff @(posedge clk) begin
      if (srst) begin
         prdata_q <= 32'h0;
      end else if (setup && !pwrite) begin
         prdata_q <= rd_mux;
      end
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         en_q <= 1'b0;
         scr_q <= 1'b0;
      end else if (wr_ok && a_ctrl) begin
         en_q <= pwdata[`JMG_CTRL_EN];
         scr_q <= pwdata[`JMG_CTRL_SCR];
      end
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         mode_q <= `JMG_MODE_RST;
         fpm_q <= `JMG_FPM_RST;
         did_q <= `JMG_DID_RST;
      end else if (wr_ok) begin
         if (a_mode) begin
            mode_q <= wmode;
         end
         if (a_fpm) begin
            fpm_q <= wfpm;
         end
         if (a_did) begin
            did_q <= pwdata[7:0];
         end
      end
   end

   // ------------------------------------------------------------
   // ILAS configuration octets
   // ------------------------------------------------------------
   wire [7:0] did_eff = did_q + {7'h0, link_q};
   wire [7:0] oct [14];
   assign oct[0] = did_eff;
   assign oct[1] = 8'h00;
   assign oct[2] = {3'h0, 2'h0, lane_q};
   assign oct[3] = {scr_q, 2'h0, l_m1};
   assign oct[4] = `JMG_F_M1;
   assign oct[5] = {3'h0, fpm_q};
   assign oct[6] = `JMG_M_M1;
   assign oct[7] = {2'h0, 1'b0, `JMG_N_M1};
   assign oct[8] = {`JMG_SUBCV, `JMG_NP_M1};
   assign oct[9] = {`JMG_JESDV, s_m1};
   assign oct[10] = 8'h00;
   assign oct[11] = 8'h00;
   assign oct[12] = 8'h00;
   wire [7:0] chk = did_eff + {5'h0, lane_q} + {7'h0, scr_q} +
                    {3'h0, l_m1} + `JMG_F_M1 + {3'h0, fpm_q} +
                    `JMG_M_M1 + {3'h0, `JMG_N_M1} +
                    {5'h0, `JMG_SUBCV} + {3'h0, `JMG_NP_M1} +
                    {5'h0, `JMG_JESDV} + {3'h0, s_m1};
   assign oct[13] = chk;

   // ------------------------------------------------------------
   // Generator: every active lane of both links, in order
   // ------------------------------------------------------------
   wire gen_rst = srst || !en_q;
   wire fifo_in_ready;
   wire push = (st_q == jmg_pkg::JMG_SEND) && fifo_in_ready;
   wire last_oct = (oct_q == `JMG_OCTETS);
   wire last_lane = ({2'h0, lane_q} == l_m1);
   wire last = last_oct && last_lane && link_q;

   always_comb begin
      st_d = st_q;
      unique case (st_q)
         jmg_pkg::JMG_IDLE: begin
            if (mode_ok) begin
               st_d = jmg_pkg::JMG_SEND;
            end
         end
         jmg_pkg::JMG_SEND: begin
            if (push && last) begin
               st_d = jmg_pkg::JMG_DONE;
            end
         end
         jmg_pkg::JMG_DONE: begin
            st_d = jmg_pkg::JMG_DONE;
         end
         default: begin
            st_d = jmg_pkg::JMG_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (gen_rst) begin
         st_q <= jmg_pkg::JMG_IDLE;
      end else begin
         st_q <= st_d;
      end
   end

   always_ff @(posedge clk) begin
      if (gen_rst) begin
         oct_q <= 4'h0;
         lane_q <= 3'h0;
         link_q <= 1'b0;
      end else if (push) begin
         oct_q <= last_oct ? 4'h0 : oct_q + 4'h1;
         if (last_oct) begin
            lane_q <= last_lane ? 3'h0 : lane_q + 3'h1;
            link_q <= link_q ^ last_lane;
         end
      end
   end

   // Back-pressure from the receiver side stalls the generator
   jmg_fifo #(
      .WIDTH(12),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .srst(gen_rst),
      .in_valid(st_q == jmg_pkg::JMG_SEND),
      .in_ready(fifo_in_ready),
      .in_data({link_q, lane_q, oct[oct_q]}),
      .out_valid(cfg_valid),
      .out_ready(cfg_ready),
      .out_data({cfg_link, cfg_lane, cfg_octet})
   );

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_interleave_des: assert property (@(posedge clk) disable iff (srst)
      interleave == !(m_d4 | m_d8 | m_d16))
      else $error("interleave flag wrong for mode");
   a_rate_factor: assert property (@(posedge clk) disable iff (srst)
      (m_s4 | m_d4) |-> (pll_mult_x4 == 5'h14))
      else $error("wrong rate factor for two lanes");
   a_lane_power: assert property (@(posedge clk) disable iff (srst)
      (en_q && m_d8) |-> (lane_en_a == 8'h0f && lane_en_b == 8'h0f))
      else $error("wrong lanes enabled");
   a_disabled_hold: assert property (@(posedge clk) disable iff (srst)
      !en_q |-> (link_rst && ser_pd && !clk_gate_en && lane_en_b == 8'h00)
      ##1 (!cfg_valid || en_q))
      else $error("link not held while disabled");
   a_fixed_zero: assert property (@(posedge clk) disable iff (srst)
      (push && (oct_q == 4'h1 || oct_q == 4'ha)) |->
      (oct[oct_q] == 8'h00))
      else $error("fixed zero field nonzero");
   a_cs_zero: assert property (@(posedge clk) disable iff (srst)
      (push && oct_q == 4'h7) |-> (oct[oct_q][7:6] == 2'h0))
      else $error("control bits field nonzero");
   a_version_one: assert property (@(posedge clk) disable iff (srst)
      (push && oct_q == 4'h8) |-> (oct[oct_q][7:5] == 3'h1))
      else $error("subclass field not one");
   a_did_link: assert property (@(posedge clk) disable iff (srst)
      (push && oct_q == 4'h0) |->
      (oct[0] == 8'(did_q + {7'h0, link_q})))
      else $error("device identifier wrong for link");
   a_frame_count: assert property (@(posedge clk) disable iff (srst)
      (push && oct_q == 4'h5) |-> (oct[5] == {3'h0, fpm_q}))
      else $error("frame count field wrong");
   a_cfg_locked: assert property (@(posedge clk) disable iff (srst)
      (acc && pwrite && a_mode && en_q) |=> $stable(mode_q))
      else $error("mode changed while enabled");
   a_chk_sum: assert property (@(posedge clk) disable iff (srst)
      (push && last_oct && m_s4 && did_q == 8'h00 && !scr_q &&
       fpm_q == 5'h11 && lane_q == 3'h0 && !link_q) |->
      (oct[13] == 8'h23))
      else $error("checksum wrong");
endmodule : jmg_top

/* File: hdl/jmg_defines.svh */
// Offsets, fields, reset values and mode codes of the ILAS generator
`ifndef JMG_DEFINES_SVH
`define JMG_DEFINES_SVH
// ---------------------------------------------------------------
// Register map
// ---------------------------------------------------------------
`define JMG_ADDR_CTRL 8'h00
`define JMG_ADDR_MODE 8'h04
`define JMG_ADDR_FPM 8'h08
`define JMG_ADDR_DID 8'h0c
`define JMG_ADDR_STAT 8'h10
`define JMG_CTRL_EN 0
`define JMG_CTRL_SCR 1
// ---------------------------------------------------------------
// Reset values and mode codes
// ---------------------------------------------------------------
`define JMG_MODE_RST 5'h04
`define JMG_FPM_RST 5'h1f
`define JMG_DID_RST 8'h00
`define JMG_MODE_S4 5'h04
`define JMG_MODE_S8 5'h05
`define JMG_MODE_D4 5'h06
`define JMG_MODE_D8 5'h07
`define JMG_MODE_S16 5'h11
`define JMG_MODE_D16 5'h12
`define JMG_FPM_MIN 5'h11
// Line rate factor R times four
`define JMG_RX4_L2 5'h14
`define JMG_RX4_L4 5'h0a
`define JMG_RX4_L8 5'h05
`define JMG_PLL_BYPASS_RX4 5'h05
// ---------------------------------------------------------------
// Fixed link parameters, minus one where sent that way
// ---------------------------------------------------------------
`define JMG_N_M1 5'h07
`define JMG_NP_M1 5'h07
`define JMG_F_M1 8'h00
`define JMG_M_M1 8'h00
`define JMG_JESDV 3'h1
`define JMG_SUBCV 3'h1
`define JMG_OCTETS 4'hd
`endif

/* File: hdl/jmg_pkg.sv */
// Types shared by the ILAS generator
package jmg_pkg;
   typedef enum logic [2:0] {
      JMG_IDLE = 3'b001,
      JMG_SEND = 3'b010,
      JMG_DONE = 3'b100
   } jmg_state_e;
endpackage : jmg_pkg

/* File: verification/jmg_rx_model.sv */
// Behavioural link receiver that collects the alignment octet stream
`timescale 1ns/100ps
module jmg_rx_model (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Bench control: back-pressure and capture clear
   input wire logic stall,
   input wire logic clr,
   // Octet stream
   input wire logic cfg_valid,
   output logic cfg_ready,
   input wire logic cfg_link,
   input wire logic [2:0] cfg_lane,
   input wire logic [7:0] cfg_octet
);
   // ------------------------------------------------------------
   // Capture
   // ------------------------------------------------------------
   // Link, lane and octet kept together so that order is checked too
   logic [11:0] mem [0:255];
   int cnt;

   assign cfg_ready = !stall;

   always_ff @(posedge clk) begin
      if (srst || clr) begin
         cnt <= 0;
      end else if (cfg_valid && cfg_ready) begin
         mem[cnt[7:0]] <= {cfg_link, cfg_lane, cfg_octet};
         cnt <= cnt + 1;
      end
   end
endmodule : jmg_rx_model

/* File: verification/jesd_mode_ilas_param_gen_tb.sv */
// Self-checking bench for the mode decoder and alignment data generator
`timescale 1ns/100ps
`include "jmg_defines.svh"
module jesd_mode_ilas_param_gen_tb;
   // ------------------------------------------------------------
   // Signals and case rows
   // ------------------------------------------------------------
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic stall = 1'b0;
   logic clr = 1'b0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, er, cfg_valid, cfg_ready, cfg_link;
   logic [2:0] cfg_lane;
   logic [7:0] cfg_octet, lane_en_a, lane_en_b;
   logic link_rst, ser_pd, clk_gate_en, interleave, pll_bypass;
   logic [4:0] pll_mult_x4;
   int fail_count = 0;
   int compares = 0;
   logic [4:0] r_mode [0:5] = '{5'h04, 5'h05, 5'h06, 5'h07, 5'h11, 5'h12};
   logic [4:0] r_fpm [0:5] = '{5'h11, 5'h1f, 5'h13, 5'h1d, 5'h15, 5'h17};
   logic [7:0] r_did [0:5] = '{8'h00, 8'hff, 8'h5a, 8'h80, 8'h3c, 8'hfe};
   logic r_scr [0:5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
   logic r_il [0:5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
   logic [4:0] r_rx4 [0:5] = '{5'h14, 5'h0a, 5'h14, 5'h0a, 5'h05, 5'h05};
   logic [3:0] r_l [0:5] = '{4'h2, 4'h4, 4'h2, 4'h4, 4'h8, 4'h8};

   jmg_top #(.FIFO_DEPTH(16)) dut_u (
      .clk(clk), .srst(srst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .cfg_valid(cfg_valid),
      .cfg_ready(cfg_ready), .cfg_link(cfg_link), .cfg_lane(cfg_lane),
      .cfg_octet(cfg_octet), .link_rst(link_rst), .ser_pd(ser_pd),
      .clk_gate_en(clk_gate_en), .interleave(interleave),
      .pll_mult_x4(pll_mult_x4), .pll_bypass(pll_bypass),
      .lane_en_a(lane_en_a), .lane_en_b(lane_en_b)
   );

   jmg_rx_model rx_u (
      .clk(clk), .srst(srst), .stall(stall), .clr(clr),
      .cfg_valid(cfg_valid), .cfg_ready(cfg_ready), .cfg_link(cfg_link),
      .cfg_lane(cfg_lane), .cfg_octet(cfg_octet)
   );

   initial begin
      forever #5 clk = ~clk;
   end

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task results;
      $display("compares=%0d fail_count=%0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : results

   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // Entered just after an edge; request held until pready is sampled
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge clk);
         i++;
      end while (pready !== 1'b1 && i < 100);
      if (i >= 100) begin
         fail_count++;
         results();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb

   task wr(input logic [7:0] a, input logic [31:0] d, input logic e);
      apb(1'b1, a, d);
      chk({31'h0, er}, {31'h0, e});
   endtask : wr

   task rd_chk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask : rd_chk

   function automatic logic [11:0] exp_word(input int i, input int n);
      logic lnk;
      logic [2:0] ln;
      logic [3:0] lm;
      logic [7:0] d, cs, o;
      lm = r_l[n] - 4'h1;
      lnk = 1'(i / (14 * r_l[n]));
      ln = 3'((i / 14) % r_l[n]);
      d = r_did[n] + {7'h0, lnk};
      // Fixed fields N-1, N'-1, revision and subclass add up to 16
      cs = d + ln + r_scr[n] + lm + r_fpm[n] + 8'h10 + lm;
      case (i % 14)
         0: o = d;
         2: o = {5'h0, ln};
         3: o = {r_scr[n], 3'h0, lm};
         5: o = {3'h0, r_fpm[n]};
         7: o = 8'h07;
         8: o = 8'h27;
         9: o = {4'h2, lm};
         13: o = cs;
         default: o = 8'h00;
      endcase
      return {lnk, ln, o};
   endfunction : exp_word

   task run_row(input int n, input logic st);
      logic [7:0] m;
      int i;
      m = 8'((9'h001 << r_l[n]) - 9'h001);
      wr(`JMG_ADDR_CTRL, 32'h0, 1'b0);
      clr <= 1'b1;
      stall <= st;
      wr(`JMG_ADDR_MODE, {27'h0, r_mode[n]}, 1'b0);
      clr <= 1'b0;
      wr(`JMG_ADDR_FPM, {27'h0, r_fpm[n]}, 1'b0);
      wr(`JMG_ADDR_DID, {24'h0, r_did[n]}, 1'b0);
      wr(`JMG_ADDR_CTRL, {30'h0, r_scr[n], 1'b1}, 1'b0);
      chk({31'h0, interleave}, {31'h0, r_il[n]});
      chk({27'h0, pll_mult_x4}, {27'h0, r_rx4[n]});
      chk({31'h0, pll_bypass}, {31'h0, r_rx4[n] == 5'h05});
      chk({16'h0, lane_en_a, lane_en_b}, {16'h0, m, m});
      chk({29'h0, link_rst, ser_pd, clk_gate_en}, 32'h1);
      apb(1'b0, `JMG_ADDR_STAT, 32'h0);
      chk(rd & ~32'h2, {12'h0, m, 3'h0, r_rx4[n] == 5'h05, r_rx4[n],
         r_il[n], 2'b01});
      if (st) begin
         repeat (40) @(posedge clk);
         chk({31'h0, cfg_valid}, 32'h1);
         chk(32'(rx_u.cnt), 32'h0);
         stall <= 1'b0;
      end
      i = 0;
      while (rx_u.cnt < 28 * r_l[n] && i < 3000) begin
         @(posedge clk);
         i++;
      end
      if (i >= 3000) begin
         fail_count++;
         results();
      end
      repeat (5) @(posedge clk);
      chk(32'(rx_u.cnt), 32'(28 * r_l[n]));
      for (i = 0; i < 28 * r_l[n]; i++) begin
         chk({20'h0, rx_u.mem[i]}, {20'h0, exp_word(i, n)});
      end
      wr(`JMG_ADDR_CTRL, 32'h0, 1'b0);
      chk({29'h0, link_rst, ser_pd, clk_gate_en}, 32'h6);
      chk({23'h0, cfg_valid, lane_en_a}, 32'h0);
   endtask : run_row

   // ------------------------------------------------------------
   // Sequence
   // ------------------------------------------------------------
   initial begin
      repeat (6) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      for (int n = 0; n < 6; n++) begin
         run_row(n, n[0]);
      end
      wr(`JMG_ADDR_MODE, 32'h08, 1'b1);
      wr(`JMG_ADDR_FPM, 32'h12, 1'b1);
      wr(`JMG_ADDR_FPM, 32'h0f, 1'b1);
      wr(`JMG_ADDR_STAT, 32'h0, 1'b1);
      apb(1'b0, 8'h20, 32'h0);
      chk({er, rd[30:0]}, 32'h80000000);
      rd_chk(`JMG_ADDR_MODE, 32'h12);
      rd_chk(`JMG_ADDR_FPM, 32'h17);
      // Abort with a full FIFO, then the next run must start clean
      stall <= 1'b1;
      wr(`JMG_ADDR_CTRL, 32'h1, 1'b0);
      repeat (30) @(posedge clk);
      wr(`JMG_ADDR_MODE, 32'h04, 1'b1);
      wr(`JMG_ADDR_CTRL, 32'h0, 1'b0);
      // Flush lands one edge after the enable bit clears
      @(posedge clk);
      chk({31'h0, cfg_valid}, 32'h0);
      run_row(0, 1'b0);
      // Reset in mid-run while enabled
      stall <= 1'b1;
      wr(`JMG_ADDR_CTRL, 32'h3, 1'b0);
      repeat (10) @(posedge clk);
      srst <= 1'b1;
      repeat (6) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      chk({28'h0, cfg_valid, link_rst, ser_pd, clk_gate_en}, 32'h6);
      rd_chk(`JMG_ADDR_CTRL, 32'h0);
      rd_chk(`JMG_ADDR_MODE, 32'h04);
      rd_chk(`JMG_ADDR_FPM, 32'h1f);
      rd_chk(`JMG_ADDR_DID, 32'h0);
      results();
   end
endmodule : jesd_mode_ilas_param_gen_tb
